// [rtl/mie_exec.sv]
// Purpose: execute xor, swap, widen, illegal trap and jump
// Assumes: jump target arrives with the opcode; memory on the same clock
// Notes: exceptions stack three entries, then fetch the vector
// What this block does
// - flag xor toggles C, V, Z, N, X where immediate bits 0-4 are set.
// - status xor applies only in supervisor state, else traps.
// - status xor is word sized and may change every bit.
// - swap exchanges all 32 bits of both registers.
// - swap modes: 01000 data pair, 01001 address pair, 10001 data/address.
// - mixed swap: first field names the data, second the address register.
// - word widen copies bit 7 to 15:8, long widen bit 15 to 31:16.
// - byte to long widen copies bit 7 to bits 31:8.
// - widen mode 010 is byte to word, 011 word to long, 111 byte to long.
// - widening sets N and Z from the result, clears V and C, keeps X.
// - the illegal opcode stacks format, pc, status and loads pc from its vector.
// - other unknown patterns get no defined operation.
// - a jump loads pc with the effective address.
// - a jump accepts only control modes.
// - swap, illegal trap and jump keep the flags.
`timescale 1ns/100ps
module mie_exec
    import mie_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h00000000,
    parameter logic [15:0] VEC_OFF_ILLEGAL = 16'h0010,
    parameter logic [15:0] VEC_OFF_PRIV = 16'h0020
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [15:0] op_word,
    input wire logic [15:0] imm_word,
    input wire logic [31:0] op_pc,
    input wire logic [31:0] ea_addr,
    input wire logic reg_wr_en,
    input wire logic [4:0] reg_wr_sel,
    input wire logic [31:0] reg_wr_data,
    input wire logic sr_wr_en,
    input wire logic [15:0] sr_wr_data,
    input wire logic [4:0] reg_rd_sel,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic op_ready_ff,
    output logic done_ff,
    output logic illegal_trap_ff,
    output logic priv_trap_ff,
    output logic unclaimed_ff,
    output logic [31:0] pc_ff,
    output logic [15:0] sr_ff,
    output logic [31:0] reg_rd_data_ff,
    output logic mem_req_ff,
    output logic mem_we_ff,
    output logic mem_long_ff,
    output logic [31:0] mem_addr_ff,
    output logic [31:0] mem_wdata_ff
);
    logic rst_meta_ff;
    logic rst_sync_n_ff;
    mie_state_e state_ff;
    mie_state_e nxt_state;
    logic [31:0] regs_ff [REG_COUNT];
    logic [31:0] stk_pc_ff;
    logic [15:0] stk_sr_ff;
    logic [15:0] vec_off_ff;
    logic [15:0] widen_sr;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_n_ff <= rst_meta_ff;
        end
    end

    // opcode fields
    wire logic [2:0] rx = op_word[RX_LSB +: REG_FIELD_W];
    wire logic [2:0] ry = op_word[RY_LSB +: REG_FIELD_W];
    wire logic [4:0] swap_mode = op_word[SWAP_MODE_LSB +: SWAP_MODE_W];
    wire logic [2:0] widen_mode = op_word[WIDEN_MODE_LSB +: REG_FIELD_W];
    wire logic [2:0] ea_mode = op_word[EA_MODE_LSB +: REG_FIELD_W];

    // group decode
    wire logic is_xor_ccr = (op_word == OP_XOR_CCR);
    wire logic is_xor_sr = (op_word == OP_XOR_SR);
    wire logic is_illegal = (op_word == OP_ILLEGAL);
    wire logic swap_group = (op_word[SWAP_TOP_LSB +: 4] == SWAP_TOP) & op_word[SWAP_FIXED_BIT];
    wire logic swap_dd = swap_group & (swap_mode == SWAP_DD);
    wire logic swap_aa = swap_group & (swap_mode == SWAP_AA);
    wire logic swap_da = swap_group & (swap_mode == SWAP_DA);
    wire logic is_swap = swap_dd | swap_aa | swap_da;
    wire logic widen_group = (op_word[WIDEN_TOP_LSB +: 7] == WIDEN_TOP)
                           & (op_word[WIDEN_LOW_LSB +: REG_FIELD_W] == WIDEN_LOW);
    wire logic widen_bw = widen_group & (widen_mode == WIDEN_BW);
    wire logic widen_wl = widen_group & (widen_mode == WIDEN_WL);
    wire logic widen_bl = widen_group & (widen_mode == WIDEN_BL);
    wire logic is_widen = widen_bw | widen_wl | widen_bl;
    wire logic is_jump = (op_word[JUMP_TOP_LSB +: 10] == JUMP_TOP);

    // control modes only; the absolute and pc forms use register 000-011
    wire logic jump_mode_ok = (ea_mode == EA_IND) | (ea_mode == EA_DISP)
                            | (ea_mode == EA_IDX)
                            | ((ea_mode == EA_EXT) & (ry <= EA_EXT_MAX_REG));

    wire logic is_super = sr_ff[SR_SUPER_BIT];
    wire logic take = op_valid & op_ready_ff;
    wire logic trap_illegal = is_illegal | (is_jump & ~jump_mode_ok);
    wire logic trap_priv = is_xor_sr & ~is_super;
    wire logic go_trap = take & (trap_illegal | trap_priv);
    wire logic claimed = is_xor_ccr | is_xor_sr | is_illegal | is_swap | is_widen | is_jump;
    wire logic go_unclaimed = take & ~claimed;
    wire logic go_simple = take & claimed & ~(trap_illegal | trap_priv);

    // swap selection; mixed mode: data in rx, address in ry
    wire logic [4:0] swap_x_idx = swap_aa ? (REG_IDX_W'(rx) + ADDR_BASE_IDX)
                                          : REG_IDX_W'(rx);
    wire logic [4:0] swap_y_idx = (swap_aa | swap_da) ? (REG_IDX_W'(ry) + ADDR_BASE_IDX)
                                                      : REG_IDX_W'(ry);
    wire logic swap_we = go_simple & is_swap;
    wire logic [31:0] swap_x_val = regs_ff[swap_x_idx];
    wire logic [31:0] swap_y_val = regs_ff[swap_y_idx];

    // sign widening of data register ry
    wire logic [31:0] widen_src = regs_ff[REG_IDX_W'(ry)];
    wire logic [31:0] res_bw = {widen_src[LONG_SIGN:WORD_SIGN+1],
                                {(WORD_SIGN-BYTE_SIGN){widen_src[BYTE_SIGN]}},
                                widen_src[BYTE_SIGN:0]};
    wire logic [31:0] res_wl = {{(LONG_SIGN-WORD_SIGN){widen_src[WORD_SIGN]}},
                                widen_src[WORD_SIGN:0]};
    wire logic [31:0] res_bl = {{(LONG_SIGN-BYTE_SIGN){widen_src[BYTE_SIGN]}},
                                widen_src[BYTE_SIGN:0]};
    wire logic [31:0] widen_res = widen_bw ? res_bw : (widen_wl ? res_wl : res_bl);
    wire logic widen_neg = widen_bw ? widen_res[WORD_SIGN] : widen_res[LONG_SIGN];
    wire logic widen_zero = widen_bw ? (widen_res[WORD_SIGN:0] == 16'h0000)
                                     : (widen_res == 32'h00000000);
    wire logic widen_we = go_simple & is_widen;

    // flags after widening; X and upper bits hold
    always_comb
    begin
        widen_sr = sr_ff;
        widen_sr[FLAG_N] = widen_neg;
        widen_sr[FLAG_Z] = widen_zero;
        widen_sr[FLAG_V] = 1'b0;
        widen_sr[FLAG_C] = 1'b0;
    end

    // status next value; other ops keep it
    wire logic [15:0] xor_ccr_sr = sr_ff ^ (imm_word & CC_MASK);
    wire logic [15:0] xor_sr_sr = sr_ff ^ imm_word;
    wire logic [15:0] nxt_sr = (go_simple & is_xor_ccr) ? xor_ccr_sr :
                               (go_simple & is_xor_sr) ? xor_sr_sr :
                               widen_we ? widen_sr : sr_ff;

    // next pc for one-cycle instructions
    wire logic [31:0] simple_len = (is_xor_ccr | is_xor_sr) ? INSTR_LEN_LONG : INSTR_LEN_SHORT;
    wire logic [31:0] simple_pc = is_jump ? ea_addr : (op_pc + simple_len);

    // stacking steps: each push lowers the stack pointer before writing
    wire logic step_fmt = go_trap;
    wire logic step_pc = (state_ff == MIE_PUSH_FMT) & mem_ack;
    wire logic step_sr = (state_ff == MIE_PUSH_PC) & mem_ack;
    wire logic step_vec = (state_ff == MIE_PUSH_SR) & mem_ack;
    wire logic step_end = (state_ff == MIE_FETCH_VEC) & mem_ack;
    wire logic push_fire = step_fmt | step_pc | step_sr;
    wire logic [31:0] push_size = step_pc ? STACK_LONG : STACK_WORD;
    wire logic [31:0] push_addr = regs_ff[SSP_IDX] - push_size;
    wire logic [15:0] trap_off = trap_priv ? VEC_OFF_PRIV : VEC_OFF_ILLEGAL;
    wire logic [31:0] push_data = step_fmt ? {16'h0000, trap_off} :
                                  step_pc ? stk_pc_ff : {16'h0000, stk_sr_ff};

    // sequencer for exception entry
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            MIE_IDLE:
                if (go_trap)
                    nxt_state = MIE_PUSH_FMT;
            MIE_PUSH_FMT:
                if (mem_ack)
                    nxt_state = MIE_PUSH_PC;
            MIE_PUSH_PC:
                if (mem_ack)
                    nxt_state = MIE_PUSH_SR;
            MIE_PUSH_SR:
                if (mem_ack)
                    nxt_state = MIE_FETCH_VEC;
            MIE_FETCH_VEC:
                if (mem_ack)
                    nxt_state = MIE_IDLE;
            default:
                nxt_state = MIE_IDLE;
        endcase
    end

    // register file; instruction writes beat the loader
    for (genvar i = 0; i < REG_COUNT; i++)
    begin : g_reg
        localparam logic [4:0] IDX = 5'(i);
        always_ff @(posedge clk or negedge rst_sync_n_ff)
        begin
            if (!rst_sync_n_ff)
                regs_ff[i] <= 32'h00000000;
            else if (swap_we && swap_x_idx == IDX)
                regs_ff[i] <= swap_y_val;
            else if (swap_we && swap_y_idx == IDX)
                regs_ff[i] <= swap_x_val;
            else if (widen_we && REG_IDX_W'(ry) == IDX)
                regs_ff[i] <= widen_res;
            else if (push_fire && IDX == SSP_IDX)
                regs_ff[i] <= push_addr;
            else if (reg_wr_en && reg_wr_sel == IDX)
                regs_ff[i] <= reg_wr_data;
        end
    end

    // state, pc, status and stacked copies
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            state_ff <= MIE_IDLE;
            pc_ff <= 32'h00000000;
            sr_ff <= SR_RESET;
            stk_pc_ff <= 32'h00000000;
            stk_sr_ff <= 16'h0000;
            vec_off_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            sr_ff <= (sr_wr_en && !take) ? sr_wr_data : nxt_sr;
            if (go_simple)
                pc_ff <= simple_pc;
            else if (step_end)
                pc_ff <= mem_rdata;
            if (go_trap)
            begin
                stk_pc_ff <= op_pc;
                stk_sr_ff <= sr_ff;
                vec_off_ff <= trap_off;
            end
        end
    end

    // handshake and pulses
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            op_ready_ff <= 1'b0;
            done_ff <= 1'b0;
            illegal_trap_ff <= 1'b0;
            priv_trap_ff <= 1'b0;
            unclaimed_ff <= 1'b0;
            reg_rd_data_ff <= 32'h00000000;
        end
        else
        begin
            op_ready_ff <= (nxt_state == MIE_IDLE);
            done_ff <= go_simple | step_end;
            illegal_trap_ff <= go_trap & ~trap_priv;
            priv_trap_ff <= go_trap & trap_priv;
            unclaimed_ff <= go_unclaimed;
            reg_rd_data_ff <= regs_ff[reg_rd_sel];
        end
    end

    // memory port; request holds until ack
    always_ff @(posedge clk or negedge rst_sync_n_ff)
    begin
        if (!rst_sync_n_ff)
        begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_long_ff <= 1'b0;
            mem_addr_ff <= 32'h00000000;
            mem_wdata_ff <= 32'h00000000;
        end
        else if (push_fire)
        begin
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b1;
            mem_long_ff <= step_pc;
            mem_addr_ff <= push_addr;
            mem_wdata_ff <= push_data;
        end
        else if (step_vec)
        begin
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b0;
            mem_long_ff <= 1'b1;
            mem_addr_ff <= VEC_BASE + {16'h0000, vec_off_ff};
            mem_wdata_ff <= 32'h00000000;
        end
        else if (mem_ack)
        begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
        end
    end
endmodule : mie_exec

// [rtl/mie_pkg.sv]
// Purpose: shared constants and types
// Assumes: 16-bit opcodes and status, 32-bit registers
// Notes: fields are lsb plus width
package mie_pkg;
    // fixed opcodes
    localparam logic [15:0] OP_XOR_CCR = 16'h0A3C;
    localparam logic [15:0] OP_XOR_SR = 16'h0A7C;
    localparam logic [15:0] OP_ILLEGAL = 16'h4AFC;
    // opcode fields
    localparam int REG_FIELD_W = 3;
    localparam int RX_LSB = 9;
    localparam int RY_LSB = 0;
    localparam int SWAP_TOP_LSB = 12;
    localparam int SWAP_FIXED_BIT = 8;
    localparam int SWAP_MODE_LSB = 3;
    localparam int SWAP_MODE_W = 5;
    localparam logic [3:0] SWAP_TOP = 4'hC;
    localparam logic [4:0] SWAP_DD = 5'h08;
    localparam logic [4:0] SWAP_AA = 5'h09;
    localparam logic [4:0] SWAP_DA = 5'h11;
    localparam int WIDEN_TOP_LSB = 9;
    localparam int WIDEN_MODE_LSB = 6;
    localparam int WIDEN_LOW_LSB = 3;
    localparam logic [6:0] WIDEN_TOP = 7'h24;
    localparam logic [2:0] WIDEN_LOW = 3'h0;
    localparam logic [2:0] WIDEN_BW = 3'h2;
    localparam logic [2:0] WIDEN_WL = 3'h3;
    localparam logic [2:0] WIDEN_BL = 3'h7;
    localparam int JUMP_TOP_LSB = 6;
    localparam logic [9:0] JUMP_TOP = 10'h13B;
    localparam int EA_MODE_LSB = 3;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_DISP = 3'h5;
    localparam logic [2:0] EA_IDX = 3'h6;
    localparam logic [2:0] EA_EXT = 3'h7;
    localparam logic [2:0] EA_EXT_MAX_REG = 3'h3;
    // status bits
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int SR_SUPER_BIT = 13;
    localparam logic [15:0] CC_MASK = 16'h001F;
    localparam logic [15:0] SR_RESET = 16'h2000;
    // sign bit positions
    localparam int BYTE_SIGN = 7;
    localparam int WORD_SIGN = 15;
    localparam int LONG_SIGN = 31;
    // regs: data, address, stack pointer
    localparam int REG_COUNT = 17;
    localparam int REG_IDX_W = 5;
    localparam logic [4:0] ADDR_BASE_IDX = 5'h08;
    localparam logic [4:0] SSP_IDX = 5'h10;
    // lengths in bytes
    localparam logic [31:0] INSTR_LEN_SHORT = 32'h00000002;
    localparam logic [31:0] INSTR_LEN_LONG = 32'h00000004;
    localparam logic [31:0] STACK_WORD = 32'h00000002;
    localparam logic [31:0] STACK_LONG = 32'h00000004;
    typedef enum logic [2:0] {
        MIE_IDLE,
        MIE_PUSH_FMT,
        MIE_PUSH_PC,
        MIE_PUSH_SR,
        MIE_FETCH_VEC
    } mie_state_e;
endpackage : mie_pkg

// [dv/mie_exec_props.sv]
// Purpose: port checks
// Assumes: one clock, raw reset disables checks
// Notes: bound from the bench top
`timescale 1ns/100ps
module mie_exec_props
    import mie_pkg::*;
#(
    parameter logic [15:0] VEC_OFF_ILLEGAL = 16'h0010,
    parameter logic [15:0] VEC_OFF_PRIV = 16'h0020
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [15:0] op_word,
    input wire logic [15:0] imm_word,
    input wire logic [31:0] op_pc,
    input wire logic [31:0] ea_addr,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic op_ready_ff,
    input wire logic done_ff,
    input wire logic illegal_trap_ff,
    input wire logic priv_trap_ff,
    input wire logic unclaimed_ff,
    input wire logic [31:0] pc_ff,
    input wire logic [15:0] sr_ff,
    input wire logic mem_req_ff,
    input wire logic mem_we_ff,
    input wire logic mem_long_ff,
    input wire logic [31:0] mem_addr_ff,
    input wire logic [31:0] mem_wdata_ff
);
    // opcode classes seen at the take edge
    wire logic take = op_valid && op_ready_ff;
    wire logic [2:0] em = op_word[5:3];
    wire logic jump_op = take && op_word[15:6] == JUMP_TOP;
    wire logic jok = em == EA_IND || em == EA_DISP || em == EA_IDX
        || (em == EA_EXT && op_word[2:0] <= EA_EXT_MAX_REG);
    wire logic wid = take && op_word[15:9] == WIDEN_TOP && em == WIDEN_LOW
        && op_word[8:6] inside {WIDEN_BW, WIDEN_WL, WIDEN_BL};
    wire logic swp = take && op_word[15:12] == SWAP_TOP && op_word[8]
        && op_word[7:3] inside {SWAP_DD, SWAP_AA, SWAP_DA};
    wire logic sxor = take && op_word == OP_XOR_SR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ccr_xor;
        take && op_word == OP_XOR_CCR |=> done_ff && sr_ff == ($past(sr_ff) ^ ($past(imm_word) & CC_MASK));
    endproperty
    a_ccr_xor: assert property (p_ccr_xor) else $error("flag xor wrong");
    property p_sr_xor;
        sxor && sr_ff[SR_SUPER_BIT] |=> sr_ff == ($past(sr_ff) ^ $past(imm_word));
    endproperty
    a_sr_xor: assert property (p_sr_xor) else $error("status xor wrong");
    property p_priv;
        sxor && !sr_ff[SR_SUPER_BIT] |=> priv_trap_ff && sr_ff == $past(sr_ff)
            && mem_wdata_ff[15:0] == VEC_OFF_PRIV;
    endproperty
    a_priv: assert property (p_priv) else $error("user status xor not trapped");
    property p_illegal;
        take && op_word == OP_ILLEGAL |=> illegal_trap_ff && mem_we_ff && !mem_long_ff
            && mem_wdata_ff[15:0] == VEC_OFF_ILLEGAL ##1 !op_ready_ff [*3];
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal entry wrong");
    property p_jump_ok;
        jump_op && jok |=> done_ff && pc_ff == $past(ea_addr) && sr_ff == $past(sr_ff);
    endproperty
    a_jump_ok: assert property (p_jump_ok) else $error("jump target wrong");
    property p_jump_bad;
        jump_op && !jok |=> illegal_trap_ff && !done_ff;
    endproperty
    a_jump_bad: assert property (p_jump_bad) else $error("bad jump mode accepted");
    property p_widen;
        wid |=> done_ff && sr_ff[FLAG_V] == 1'b0 && sr_ff[FLAG_C] == 1'b0
            && (sr_ff & 16'hFFF0) == ($past(sr_ff) & 16'hFFF0);
    endproperty
    a_widen: assert property (p_widen) else $error("widen flags wrong");
    property p_swap;
        swp |=> done_ff && sr_ff == $past(sr_ff) && pc_ff == $past(op_pc) + INSTR_LEN_SHORT;
    endproperty
    a_swap: assert property (p_swap) else $error("swap touched flags");
    property p_unclaimed;
        take && op_word == 16'hFFFF |=> unclaimed_ff && !done_ff && $stable(pc_ff);
    endproperty
    a_unclaimed: assert property (p_unclaimed) else $error("reserved pattern acted");
    property p_req_hold;
        mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff) && $stable(mem_wdata_ff);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request moved");
    property p_vec;
        mem_req_ff && !mem_we_ff && mem_ack |=> done_ff && op_ready_ff && pc_ff == $past(mem_rdata);
    endproperty
    a_vec: assert property (p_vec) else $error("vector load wrong");
    c_jump: cover property (jump_op && jok);
    c_priv: cover property (sxor && !sr_ff[SR_SUPER_BIT]);
    c_vec: cover property (mem_req_ff && !mem_we_ff && mem_ack);
endmodule : mie_exec_props

// [dv/mie_mem_model.sv]
// Purpose: stacking memory
// Assumes: requests held until ack
// Notes: slow adds wait states; rdata toggles outside reads
`timescale 1ns/100ps
module mie_mem_model #(
    parameter logic [31:0] VEC_TGT = 32'h00000400
)(
    input wire logic clk,
    input wire logic slow,
    input wire logic mem_req_ff,
    input wire logic mem_we_ff,
    input wire logic mem_long_ff,
    input wire logic [31:0] mem_addr_ff,
    input wire logic [31:0] mem_wdata_ff,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] addr_q[$];
    logic [31:0] data_q[$];
    int wait_cnt = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h5A5A5A5A;
    // one ack per request; stale read data never lingers
    always @(negedge clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req_ff && !mem_ack && wait_cnt < (slow ? 3 : 0))
            wait_cnt <= wait_cnt + 1;
        else if (mem_req_ff && !mem_ack)
        begin
            wait_cnt <= 0;
            mem_ack <= 1'b1;
            addr_q.push_back(mem_addr_ff);
            data_q.push_back(!mem_we_ff ? 32'h0 : mem_long_ff ? mem_wdata_ff
                : {16'h0, mem_wdata_ff[15:0]});
            if (!mem_we_ff)
                mem_rdata <= VEC_TGT;
        end
    end
endmodule : mie_mem_model

// [dv/test_misc_instruction_exec.sv]
// Purpose: self-checking bench
// Assumes: inputs change at the falling edge
// Notes: registers mirrored in m_reg
`timescale 1ns/100ps
module test_misc_instruction_exec;
    import mie_pkg::*;
    localparam logic [31:0] VEC_TGT = 32'h00000400;
    logic clk, rst_n, op_valid, reg_wr_en, sr_wr_en, slow, mem_ack, op_ready_ff, done_ff;
    logic illegal_trap_ff, priv_trap_ff, unclaimed_ff, mem_req_ff, mem_we_ff, mem_long_ff;
    logic [15:0] op_word, imm_word, sr_wr_data, sr_ff, m_sr;
    logic [31:0] op_pc, ea_addr, reg_wr_data, mem_rdata, reg_rd_data_ff, pc_ff, mem_addr_ff;
    logic [31:0] mem_wdata_ff, m_pc, d, r, supervisor_stack_pointer;
    logic [4:0] reg_wr_sel, reg_rd_sel;
    logic [31:0] m_reg [REG_COUNT];
    logic [31:0] exp_q[$];
    integer seed = 32'hd2d0;
    int error_cnt = 0;
    int checks = 0;
    int a, b;
    mie_exec dut_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_word(op_word),
        .imm_word(imm_word), .op_pc(op_pc), .ea_addr(ea_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .sr_wr_en(sr_wr_en),
        .sr_wr_data(sr_wr_data), .reg_rd_sel(reg_rd_sel), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .op_ready_ff(op_ready_ff), .done_ff(done_ff),
        .illegal_trap_ff(illegal_trap_ff), .priv_trap_ff(priv_trap_ff),
        .unclaimed_ff(unclaimed_ff), .pc_ff(pc_ff), .sr_ff(sr_ff),
        .reg_rd_data_ff(reg_rd_data_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff),
        .mem_long_ff(mem_long_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff));
    mie_mem_model #(.VEC_TGT(VEC_TGT)) mem_u (.clk(clk), .slow(slow),
        .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_long_ff(mem_long_ff),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    // keep: op_valid stays up for back to back ops
    task automatic issue(input logic [15:0] op, input logic [15:0] imm, input logic keep);
        if (!op_valid)
            @(negedge clk);
        for (int n = 0; n < 60 && op_ready_ff !== 1'b1; n++)
            @(negedge clk);
        op_valid = 1'b1;
        op_word = op;
        imm_word = imm;
        op_pc = $random(seed) & 32'hFFFFFFFE;
        ea_addr = $random(seed) & 32'hFFFFFFFE;
        @(negedge clk);
        if (!keep)
            op_valid = 1'b0;
    endtask : issue
    task automatic post(input logic [31:0] pc);
        m_pc = pc;
        chk({31'h0, done_ff}, 32'h1, "done");
        chk(pc_ff, m_pc, "pc");
        chk({16'h0, sr_ff}, {16'h0, m_sr}, "status");
    endtask : post
    // exception entry stacking
    task automatic trap(input logic [15:0] off, input logic pv);
        chk({31'h0, pv ? priv_trap_ff : illegal_trap_ff}, 32'h1, "trap pulse");
        for (int n = 0; n < 80 && done_ff !== 1'b1; n++)
            @(negedge clk);
        supervisor_stack_pointer = m_reg[SSP_IDX];
        exp_q = '{supervisor_stack_pointer - 2, {16'h0, off}, supervisor_stack_pointer - 6, op_pc, supervisor_stack_pointer - 8, {16'h0, m_sr}, {16'h0, off}, 0};
        chk(mem_u.addr_q.size(), 4, "push count");
        for (int i = 0; i < 4 && i < mem_u.addr_q.size(); i++)
        begin
            chk(mem_u.addr_q[i], exp_q[2 * i], "stack address");
            chk(mem_u.data_q[i], exp_q[2 * i + 1], "stack data");
        end
        mem_u.addr_q.delete();
        mem_u.data_q.delete();
        m_reg[SSP_IDX] = supervisor_stack_pointer - 8;
        post(VEC_TGT);
    endtask : trap
    task automatic rd_all;
        for (int i = 0; i < REG_COUNT; i++)
        begin
            reg_rd_sel = i[4:0];
            @(negedge clk);
            chk(reg_rd_data_ff, m_reg[i], "register");
        end
    endtask : rd_all
    task automatic load(input int sel, input logic [31:0] v);
        reg_wr_en = 1'b1;
        reg_wr_sel = sel[4:0];
        reg_wr_data = v;
        m_reg[sel] = v;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask : load
    // scenarios
    initial
    begin
        {rst_n, op_valid, reg_wr_en, sr_wr_en, slow} = 0;
        {op_word, imm_word, sr_wr_data, op_pc, ea_addr, reg_wr_data} = 0;
        {reg_wr_sel, reg_rd_sel} = 0;
        m_sr = SR_RESET;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < REG_COUNT; i++)
            load(i, i == SSP_IDX ? 32'h00002000 : $random(seed));
        for (int i = 0; i < 4; i++)
        begin
            imm_word = $random(seed);
            m_sr = m_sr ^ (imm_word & CC_MASK);
            issue(OP_XOR_CCR, imm_word, i < 3);
            post(op_pc + 4);
        end
        d = $random(seed) & 32'h0000DFFF;
        m_sr = m_sr ^ d[15:0];
        issue(OP_XOR_SR, d[15:0], 1'b1);
        post(op_pc + 4);
        m_sr = m_sr ^ 16'h2000;
        issue(OP_XOR_SR, 16'h2000, 1'b1);
        post(op_pc + 4);
        issue(OP_XOR_SR, 16'hFFFF, 1'b0);
        trap(16'h0020, 1'b1);
        sr_wr_en = 1'b1;
        sr_wr_data = SR_RESET;
        m_sr = SR_RESET;
        @(negedge clk);
        sr_wr_en = 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            a = $random(seed) & 7;
            b = $random(seed) & 7;
            d = k % 3 == 0 ? SWAP_DD : k % 3 == 1 ? SWAP_AA : SWAP_DA;
            if (d[4:0] == SWAP_AA)
                a = a + 8;
            if (d[4:0] != SWAP_DD)
                b = b + 8;
            {m_reg[a], m_reg[b]} = {m_reg[b], m_reg[a]};
            issue({SWAP_TOP, a[2:0], 1'b1, d[4:0], b[2:0]}, 16'h0, k < 8);
            post(op_pc + 2);
        end
        rd_all();
        for (int k = 0; k < 9; k++)
        begin
            a = $random(seed) & 7;
            d = k % 3 == 0 ? WIDEN_BW : k % 3 == 1 ? WIDEN_WL : WIDEN_BL;
            r = k < 3 ? 32'hFFFF0000 : k < 6 ? 32'h12348080 : $random(seed);
            load(a, r);
            if (d[2:0] == WIDEN_BW)
                r = {r[31:16], {8{r[7]}}, r[7:0]};
            else
                r = d[2:0] == WIDEN_WL ? {{16{r[15]}}, r[15:0]} : {{24{r[7]}}, r[7:0]};
            m_reg[a] = r;
            b = d[2:0] == WIDEN_BW ? 15 : 31;
            m_sr = {m_sr[15:4], r[b], (d[2:0] == WIDEN_BW ? r[15:0] == 0 : r == 0), 2'b00};
            issue({WIDEN_TOP, d[2:0], WIDEN_LOW, a[2:0]}, 16'h0, 1'b0);
            post(op_pc + 2);
            reg_rd_sel = a[4:0];
            @(negedge clk);
            chk(reg_rd_data_ff, m_reg[a], "widen result");
        end
        for (int k = 0; k < 13; k++)
        begin
            slow = k[0];
            a = k < 8 ? k : 7;
            b = k < 8 ? 1 : k - 8;
            issue({JUMP_TOP, a[2:0], b[2:0]}, 16'h0, 1'b0);
            if (a == 2 || a == 5 || a == 6 || (a == 7 && b <= 3))
                post(ea_addr);
            else
                trap(16'h0010, 1'b0);
        end
        issue(OP_ILLEGAL, 16'h0, 1'b0);
        trap(16'h0010, 1'b0);
        issue(16'hFFFF, 16'h0, 1'b0);
        chk({30'h0, unclaimed_ff, done_ff}, 32'h2, "reserved pattern");
        chk(pc_ff, m_pc, "reserved pc");
        test_done();
    end
    // hang guard
    initial
    begin
        #(20000 * 8);
        error_cnt++;
        $display("mismatch at %0t: timeout", $time);
        test_done();
    end
endmodule : test_misc_instruction_exec
bind mie_exec mie_exec_props #(.VEC_OFF_ILLEGAL(VEC_OFF_ILLEGAL), .VEC_OFF_PRIV(VEC_OFF_PRIV))
    props_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_word(op_word),
    .imm_word(imm_word), .op_pc(op_pc), .ea_addr(ea_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .op_ready_ff(op_ready_ff), .done_ff(done_ff),
    .illegal_trap_ff(illegal_trap_ff), .priv_trap_ff(priv_trap_ff),
    .unclaimed_ff(unclaimed_ff), .pc_ff(pc_ff), .sr_ff(sr_ff), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_long_ff(mem_long_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff));
